/* File: logic/iab_pkg.sv */
// Shared constants and types for the indirect pointer and bit-op datapath
package iab_pkg;

  // ==========================================================================
  // Register bus map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0c;
  localparam logic [7:0] REG_DADDR = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_SKIP_BIT = 1;
  localparam int unsigned STAT_TEST_BIT = 2;
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [11:0] INSTR_RST = 12'h000;
  localparam logic [6:0] DADDR_RST = 7'h00;

  // ==========================================================================
  // Instruction word and file map
  localparam int unsigned INSTR_W = 12;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_BIT_TEST = 4'h6;
  localparam logic [4:0] FADDR_INDIRECT = 5'h00;
  localparam logic [4:0] FADDR_POINTER = 5'h04;
  localparam logic [4:0] FADDR_LOW_ZERO = 5'h00;
  localparam logic [1:0] BANK_ZERO = 2'h0;
  localparam logic [1:0] PTR_UNIMPL_RD = 2'h3;
  localparam logic PTR_TOP_RD = 1'b1;
  localparam logic [7:0] NULL_READ = 8'h00;
  localparam int unsigned MEM_DEPTH = 128;

  // ==========================================================================
  // Timing: core clocks per instruction cycle
  localparam int unsigned CYC_DIV_DEF = 4;

  typedef enum logic [1:0]
  {
    IAB_OP_NOP = 2'b00,
    IAB_OP_SET = 2'b01,
    IAB_OP_TEST = 2'b10
  } iab_op_e;

endpackage

/* File: logic/iab_cyc_div.sv */
// Instruction-cycle enable divider
`timescale 1ns/1ps
`default_nettype none

module iab_cyc_div #(
  parameter int unsigned DIV = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);

  // ==========================================================================
  // Counter wraps at DIV-1 and emits a one-clock pulse
  logic [15:0] cnt_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 16'h0000;
      tick_out <= 1'b0;
    end
    else if (cnt_reg == 16'(DIV - 1))
    begin
      cnt_reg <= 16'h0000;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: logic/iab_bit_unit.sv */
// Single-bit set and test on an eight-bit operand
`timescale 1ns/1ps
`default_nettype none

module iab_bit_unit (
  input wire logic [7:0] val_in,
  input wire logic [2:0] bit_in,
  output logic [7:0] set_val_out,
  output logic bit_val_out
);

  // ==========================================================================
  // Per-bit select: only the chosen bit is forced, the rest pass through
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bit
      assign set_val_out[gi] = val_in[gi] | (bit_in == 3'(gi));
    end
  endgenerate

  // Tested bit taken straight from the operand
  assign bit_val_out = val_in[bit_in];

endmodule
`default_nettype wire

/* File: logic/iab_top.sv */
// Indirect pointer, data memory and bit set / bit test-skip datapath
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module iab_top #(
  parameter bit BANKED = 1'b1,
  parameter int unsigned CYC_DIV = iab_pkg::CYC_DIV_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic FLUSH_OUT
);

  // ==========================================================================
  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // State
  logic [7:0] mem_reg [iab_pkg::MEM_DEPTH];
  logic [6:0] ptr_reg;
  logic [11:0] instr_reg;
  logic pending_reg;
  logic skip_reg;
  logic test_reg;
  logic run_reg;
  logic [6:0] daddr_reg;
  logic tick;

  iab_cyc_div #(
    .DIV(CYC_DIV)
  ) u_div (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n_reg),
    .tick_out(tick)
  );

  // ==========================================================================
  // Decode of the held instruction word
  logic [3:0] opc;
  logic [2:0] bitn;
  logic [4:0] fadr;
  iab_pkg::iab_op_e op;

  assign opc = instr_reg[11:8];
  assign bitn = instr_reg[7:5];
  assign fadr = instr_reg[4:0];

  // Other opcodes run as no-ops here; they belong to other units
  always_comb
  begin
    case (opc)
      iab_pkg::OPC_BIT_SET: op = iab_pkg::IAB_OP_SET;
      iab_pkg::OPC_BIT_TEST: op = iab_pkg::IAB_OP_TEST;
      default: op = iab_pkg::IAB_OP_NOP;
    endcase
  end

  // ==========================================================================
  // Pointer read view and operand address resolution
  logic [7:0] ptr_rd;
  logic [1:0] bank;

  generate
    if (BANKED)
    begin : g_banked
      assign ptr_rd = {iab_pkg::PTR_TOP_RD, ptr_reg};
      assign bank = ptr_reg[6:5];
    end
    else
    begin : g_flat
      // Upper pointer bits have no storage
      assign ptr_rd = {iab_pkg::PTR_TOP_RD, iab_pkg::PTR_UNIMPL_RD,
                       ptr_reg[4:0]};
      assign bank = iab_pkg::BANK_ZERO;
    end
  endgenerate

  logic ind;
  logic null_ptr;
  logic [4:0] tgt_f;
  logic tgt_is_ptr;
  logic [6:0] ea;
  logic [7:0] rd_val;

  // Indirect port redirects to the pointer target
  assign ind = fadr == iab_pkg::FADDR_INDIRECT;
  assign null_ptr = ind && (ptr_reg[4:0] == iab_pkg::FADDR_LOW_ZERO);
  assign tgt_f = ind ? ptr_reg[4:0] : fadr;
  assign tgt_is_ptr = tgt_f == iab_pkg::FADDR_POINTER;
  assign ea = {bank, tgt_f};
  assign rd_val = null_ptr ? iab_pkg::NULL_READ :
                  tgt_is_ptr ? ptr_rd : mem_reg[ea];

  logic [7:0] set_val;
  logic bit_val;

  iab_bit_unit u_bit (
    .val_in(rd_val),
    .bit_in(bitn),
    .set_val_out(set_val),
    .bit_val_out(bit_val)
  );

  // ==========================================================================
  // Execute strobes, one per instruction cycle
  logic exec;
  logic exec_real;
  logic do_set;
  logic do_skip;

  assign exec = tick && pending_reg && run_reg;
  // A pending skip turns this slot into a no-op
  assign exec_real = exec && !skip_reg;
  assign do_set = exec_real && (op == iab_pkg::IAB_OP_SET) && !null_ptr;
  assign do_skip = exec_real && (op == iab_pkg::IAB_OP_TEST) && !bit_val;

  // ==========================================================================
  // Register bus: one wait state, error on unmapped or busy instruction
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic access;
  logic done;
  logic mapped;
  logic wr_ok;

  assign access = PSEL_IN && PENABLE_IN && !pready_reg;
  assign done = PSEL_IN && PENABLE_IN && pready_reg;
  assign wr_ok = done && PWRITE_IN && !pslverr_reg;

  always_comb
  begin
    case (PADDR_IN)
      iab_pkg::REG_CTRL,
      iab_pkg::REG_INSTR,
      iab_pkg::REG_STAT,
      iab_pkg::REG_PTR,
      iab_pkg::REG_DADDR,
      iab_pkg::REG_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Ready, error and read data all settle in the cycle after the access cycle
  always_ff @(posedge CLK_IN or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && (!mapped || (PWRITE_IN && pending_reg &&
                     PADDR_IN == iab_pkg::REG_INSTR));
      if (access && !PWRITE_IN)
      begin
        case (PADDR_IN)
          iab_pkg::REG_CTRL: prdata_reg <= {31'h0, run_reg};
          iab_pkg::REG_INSTR: prdata_reg <= {20'h0, instr_reg};
          iab_pkg::REG_STAT: prdata_reg <= {29'h0, test_reg, skip_reg,
                                            pending_reg};
          iab_pkg::REG_PTR: prdata_reg <= {24'h0, ptr_rd};
          iab_pkg::REG_DADDR: prdata_reg <= {25'h0, daddr_reg};
          iab_pkg::REG_DATA: prdata_reg <= {24'h0, mem_reg[daddr_reg]};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Software control registers
  always_ff @(posedge CLK_IN or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      run_reg <= iab_pkg::CTRL_RUN_RST;
      daddr_reg <= iab_pkg::DADDR_RST;
    end
    else if (wr_ok && PADDR_IN == iab_pkg::REG_CTRL)
      run_reg <= PWDATA_IN[iab_pkg::CTRL_RUN_BIT];
    else if (wr_ok && PADDR_IN == iab_pkg::REG_DADDR)
      daddr_reg <= PWDATA_IN[6:0];
  end

  // Instruction slot: a write loads it, execution frees it
  always_ff @(posedge CLK_IN or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      instr_reg <= iab_pkg::INSTR_RST;
      pending_reg <= 1'b0;
    end
    else if (wr_ok && PADDR_IN == iab_pkg::REG_INSTR)
    begin
      instr_reg <= PWDATA_IN[11:0];
      pending_reg <= 1'b1;
    end
    else if (exec)
      pending_reg <= 1'b0;
  end

  // Skip marker lives until the next instruction slot is consumed
  always_ff @(posedge CLK_IN or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      skip_reg <= 1'b0;
      FLUSH_OUT <= 1'b0;
      test_reg <= 1'b0;
    end
    else
    begin
      FLUSH_OUT <= do_skip;
      if (exec)
        skip_reg <= do_skip;
      if (exec_real && op == iab_pkg::IAB_OP_TEST)
        test_reg <= bit_val;
    end
  end

  // ==========================================================================
  // Pointer register: bit set wins over a bus write in the same cycle
  logic [6:0] ptr_next;
  logic [7:0] ptr_src;

  assign ptr_src = (do_set && tgt_is_ptr) ? set_val : PWDATA_IN[7:0];
  assign ptr_next = BANKED ? ptr_src[6:0] : {2'b00, ptr_src[4:0]};

  always_ff @(posedge CLK_IN or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      ptr_reg <= iab_pkg::PTR_RST;
    else if ((do_set && tgt_is_ptr) ||
             (wr_ok && PADDR_IN == iab_pkg::REG_PTR))
      ptr_reg <= ptr_next;
  end

  // Data memory has no reset; contents are undefined until written
  always_ff @(posedge CLK_IN)
  begin
    if (wr_ok && PADDR_IN == iab_pkg::REG_DATA)
      mem_reg[daddr_reg] <= PWDATA_IN[7:0];
    if (do_set && !tgt_is_ptr)
      mem_reg[ea] <= set_val;
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = pready_reg;
  assign PSLVERR_OUT = pslverr_reg;

  // ==========================================================================
  // Checks
  logic [6:0] chk_ea_reg;
  logic [7:0] chk_exp_reg;

  // Expected result is built independently of the bit unit
  always_ff @(posedge CLK_IN)
  begin
    chk_ea_reg <= ea;
    chk_exp_reg <= rd_val | (8'h01 << bitn);
  end

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!rst_n_reg);

  chk_ptr_width: assert property (!BANKED |-> ptr_reg[6:5] == 2'b00)
    else $error("unbanked pointer holds upper bits");
  chk_low_range: assert property (ind && !null_ptr |->
    ea[4:0] == ptr_reg[4:0])
    else $error("indirect low address differs from pointer");
  chk_unimpl_ones: assert property (!BANKED |-> ptr_rd[6:5] == 2'b11)
    else $error("unbanked pointer upper bits not ones");
  chk_bank_select: assert property (BANKED |-> ea[6:5] == ptr_reg[6:5])
    else $error("bank does not follow pointer");
  chk_null_read: assert property (null_ptr |-> rd_val == 8'h00)
    else $error("null indirect read not zero");
  chk_null_write: assert property (exec_real && null_ptr |->
    !do_set ##1 $stable(ptr_reg))
    else $error("null indirect write took effect");
  chk_set_result: assert property (do_set && !tgt_is_ptr |=>
    mem_reg[chk_ea_reg] == chk_exp_reg)
    else $error("bit set result wrong");
  chk_indirect_hit: assert property (do_set && ind && !tgt_is_ptr |=>
    mem_reg[{$past(bank), $past(ptr_reg[4:0])}] == chk_exp_reg)
    else $error("indirect write missed pointer target");
  chk_skip_flush: assert property (exec_real &&
    op == iab_pkg::IAB_OP_TEST && !bit_val |=> FLUSH_OUT && skip_reg)
    else $error("skip not taken on clear bit");
  chk_no_skip: assert property (exec_real &&
    op == iab_pkg::IAB_OP_TEST && bit_val |=> !FLUSH_OUT && !skip_reg)
    else $error("skip taken on set bit");
  chk_skip_nop: assert property (exec && skip_reg |->
    !do_set ##1 !skip_reg && !pending_reg)
    else $error("discarded slot was not a no-op");
  chk_rmw_keep: assert property (do_set && tgt_is_ptr |=>
    ptr_rd == (chk_exp_reg | (BANKED ? 8'h80 : 8'he0)))
    else $error("pointer read-modify-write lost bits");

endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the indirect pointer and bit-op datapath
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================================
  // Signals, counters and the queue of expected bus results
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rdata_a;
  logic [31:0] rdata_b;
  logic ready_a;
  logic ready_b;
  logic err_a;
  logic err_b;
  logic flush_a;
  logic flush_b;
  int fail_count;
  int cmp_count;
  int flush_a_n;
  int flush_b_n;
  int exp_flush;
  integer seed;
  logic [65:0] note;
  logic [65:0] note_q[$];

  // Banked and unbanked copies share one bus, so every access hits both
  iab_top #(.BANKED(1'h1), .CYC_DIV(2)) iab_top_i (.CLK_IN(clk),
    .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(rdata_a), .PREADY_OUT(ready_a), .PSLVERR_OUT(err_a),
    .FLUSH_OUT(flush_a));
  iab_top #(.BANKED(1'h0), .CYC_DIV(2)) iab_top_u_i (.CLK_IN(clk),
    .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(rdata_b), .PREADY_OUT(ready_b), .PSLVERR_OUT(err_b),
    .FLUSH_OUT(flush_b));

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Whole run needs under a thousand cycles; this is far beyond it
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  // ==========================================================================
  // Checking helpers
  task automatic miss(input string m);
    $display("MISMATCH %0t %s", $time, m);
    fail_count++;
  endtask

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Monitor: counts flush cycles, pairs each bus answer with the oldest note
  always @(posedge clk)
  begin
    if (flush_a === 1'h1)
      flush_a_n++;
    if (flush_b === 1'h1)
      flush_b_n++;
    if (ready_a === 1'h1)
    begin
      cmp_count++;
      if (note_q.size() == 0)
        miss("unexpected bus answer");
      else
      begin
        note = note_q.pop_front();
        if (err_a !== note[0] || err_b !== note[0] || ready_b !== 1'h1 ||
            (note[65] && (rdata_a !== note[64:33] ||
            rdata_b !== note[32:1])))
          miss("bus result");
      end
    end
  end

  task automatic fchk();
    cmp_count++;
    if (flush_a_n != exp_flush || flush_b_n != exp_flush)
      miss("flush count");
  endtask

  // ==========================================================================
  // Bus master: setup, access, hold until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] ea, input logic [31:0] eb,
    input logic er);
    int n;
    begin
      note_q.push_back({~w, ea, eb, er});
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      @(posedge clk);
      while (ready_a !== 1'h1 && n < 20)
      begin
        n++;
        @(posedge clk);
      end
      if (n == 20)
        miss("no ready");
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic er);
    xfer(1'h1, a, d, 32'h0, 32'h0, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ea,
    input logic [31:0] eb);
    xfer(1'h0, a, 32'h0, ea, eb, 1'h0);
  endtask

  // Instruction load; tick every two clocks, so six clocks cover execution
  task automatic op(input logic [3:0] opc, input logic [2:0] b,
    input logic [4:0] f);
    wr(iab_pkg::REG_INSTR, {20'h0, opc, b, f}, 1'h0);
    repeat (6) @(posedge clk);
  endtask

  task automatic mset(input logic [6:0] a, input logic [7:0] v);
    wr(iab_pkg::REG_DADDR, {25'h0, a}, 1'h0);
    wr(iab_pkg::REG_DATA, {24'h0, v}, 1'h0);
  endtask

  task automatic mchk(input logic [6:0] a, input logic [7:0] ea,
    input logic [7:0] eb);
    wr(iab_pkg::REG_DADDR, {25'h0, a}, 1'h0);
    rd(iab_pkg::REG_DATA, {24'h0, ea}, {24'h0, eb});
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [6:0] r;
    logic [1:0] bk;
    logic [4:0] f;
    logic [7:0] v;
    logic [7:0] acc;
    logic [7:0] acc2;
    logic [7:0] t;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rst_n = 1'h0;
    seed = 32'hfe6a;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    // Reset state and an unmapped address
    rd(iab_pkg::REG_CTRL, 32'h1, 32'h1);
    rd(iab_pkg::REG_PTR, 32'h80, 32'he0);
    rd(iab_pkg::REG_STAT, 32'h0, 32'h0);
    xfer(1'h0, 8'h3c, 32'h0, 32'h0, 32'h0, 1'h1);
    // Pointer width: seven bits banked, five plus ones unbanked
    r = 7'($random(seed));
    wr(iab_pkg::REG_PTR, {25'h0, r}, 1'h0);
    rd(iab_pkg::REG_PTR, {25'h1, r}, {24'h0, 3'h7, r[4:0]});
    // Bit set on the pointer itself; unbanked copy keeps only five bits
    op(iab_pkg::OPC_BIT_SET, 3'h2, iab_pkg::FADDR_POINTER);
    rd(iab_pkg::REG_PTR, {25'h1, r | 7'h04},
      {24'h0, 3'h7, r[4:0] | 5'h04});
    // Indirect bit set in a non-zero bank; unbanked copy stays in bank 0
    bk = 2'($random(seed));
    if (bk == 2'h0)
      bk = 2'h2;
    f = 5'($random(seed));
    if (f < 5'h5)
      f = f + 5'h5;
    v = 8'($random(seed));
    mset({bk, f}, v);
    mset({2'h0, f}, ~v);
    wr(iab_pkg::REG_PTR, {25'h0, bk, f}, 1'h0);
    acc = v;
    acc2 = ~v;
    for (int b = 0; b < 8; b++)
    begin
      op(iab_pkg::OPC_BIT_SET, 3'(b), iab_pkg::FADDR_INDIRECT);
      acc[b] = 1'h1;
      acc2[b] = 1'h1;
      mchk({bk, f}, acc, v);
      mchk({2'h0, f}, ~v, acc2);
    end
    // Null pointer: write dropped, read gives zero so the test skips
    mset({bk, 5'h0}, 8'h5a);
    mset(7'h0, 8'h5a);
    mset({bk, f}, 8'h0);
    mset({2'h0, f}, 8'h0);
    wr(iab_pkg::REG_PTR, {25'h0, bk, 5'h0}, 1'h0);
    op(iab_pkg::OPC_BIT_SET, 3'h0, iab_pkg::FADDR_INDIRECT);
    mchk({bk, 5'h0}, 8'h5a, 8'h5a);
    mchk(7'h0, 8'h5a, 8'h5a);
    op(iab_pkg::OPC_BIT_TEST, 3'h1, iab_pkg::FADDR_INDIRECT);
    exp_flush++;
    fchk();
    rd(iab_pkg::REG_STAT, 32'h2, 32'h2);
    // The next word after a taken skip is discarded
    op(iab_pkg::OPC_BIT_SET, 3'h3, f);
    mchk({bk, f}, 8'h0, 8'h0);
    rd(iab_pkg::REG_STAT, 32'h0, 32'h0);
    op(iab_pkg::OPC_BIT_SET, 3'h3, f);
    mchk({bk, f}, 8'h8, 8'h0);
    mchk({2'h0, f}, 8'h0, 8'h8);
    // Bit test on every bit index of a random byte
    t = 8'($random(seed));
    t[1:0] = 2'h2;
    mset({bk, f}, t);
    mset({2'h0, f}, t);
    for (int b = 0; b < 8; b++)
    begin
      op(iab_pkg::OPC_BIT_TEST, 3'(b), f);
      if (!t[b])
        exp_flush++;
      fchk();
      rd(iab_pkg::REG_STAT, {29'h0, t[b], ~t[b], 1'h0},
        {29'h0, t[b], ~t[b], 1'h0});
      if (!t[b])
        op(4'h0, 3'h0, 5'h0);
    end
    // Frozen execution: a second load is refused, the first runs later
    mset({bk, f}, 8'h0);
    mset({2'h0, f}, 8'h0);
    wr(iab_pkg::REG_CTRL, 32'h0, 1'h0);
    wr(iab_pkg::REG_INSTR, {20'h0, iab_pkg::OPC_BIT_SET, 3'h6, f}, 1'h0);
    wr(iab_pkg::REG_INSTR, {20'h0, iab_pkg::OPC_BIT_SET, 3'h1, f}, 1'h1);
    repeat (6) @(posedge clk);
    mchk({bk, f}, 8'h0, 8'h0);
    // Last tested bit stays in the status word from the test loop
    rd(iab_pkg::REG_STAT, {29'h0, t[7], 2'h1}, {29'h0, t[7], 2'h1});
    wr(iab_pkg::REG_CTRL, 32'h1, 1'h0);
    repeat (6) @(posedge clk);
    mchk({bk, f}, 8'h40, 8'h0);
    mchk({2'h0, f}, 8'h0, 8'h40);
    fchk();
    repeat (4) @(posedge clk);
    stop_test();
  end

endmodule

`default_nettype wire
